/* hw/spf_pair_decode.sv */
// Decoder from one selection field to the pad controls of its pin pair.
module spf_pair_decode
  import spf_pkg::*;
#(
  parameter spf_kind_t   KIND  = SPF_KIND_USB,
  parameter int unsigned GROUP = SPF_GRP_A
) (
  input  wire logic [1:0] code,  // Field value
  output spf_pair_t       pads   // Pad controls
);

  always_comb begin
    pads = '0;
    if (KIND == SPF_KIND_USB) begin
      if (code[0]) begin // see RULE_02, RULE_14
        pads.p0_func = 1'b1;
        pads.p1_func = 1'b1;
        pads.p0_cut  = 1'b1;
        pads.p1_cut  = 1'b1;
      end
    end else if (spf_osc_legal(code, GROUP)) begin // see RULE_15
      case (code)
        SPF_OSC_GPIO: begin // see RULE_04, RULE_07
          // The first pin stays GPIO but may also feed a clock input.
          if (KIND == SPF_KIND_MAIN) begin
            pads.clk_in = (GROUP == SPF_GRP_C);
          end else begin
            pads.clk_in = (GROUP != SPF_GRP_C);
          end
        end
        SPF_OSC_XTAL: begin // see RULE_05, RULE_08
          pads.p0_func = 1'b1;
          pads.p1_func = 1'b1;
          pads.p0_cut  = 1'b1;
          pads.p1_cut  = 1'b1;
          pads.pu_off  = 1'b1;
          pads.clk_in  = (KIND == SPF_KIND_MAIN) && (GROUP == SPF_GRP_A);
        end
        SPF_OSC_EXT: begin // see RULE_06, RULE_09
          // Input path must stay open for the clock, second pin is GPIO.
          pads.p0_func = 1'b1;
          pads.clk_in  = 1'b1;
        end
        default: begin
          pads = '0;
        end
      endcase
    end
  end

endmodule // spf_pair_decode

/* hw/spf_pin_select.sv */
// Special pin function selection register and pad control of its pin pairs.
//
// Summary of operation
// (RULE_01) USB ch0 field 0, the reset value, keeps both USB ch0 pins as GPIO.
// (RULE_02) USB ch0 field 1 gives both pins to USB, input direction, cut-off.
// (RULE_03) Reading returns every stored field and changes no pin.
// (RULE_04) Main oscillator field 00 releases both pins to GPIO.
// (RULE_05) Main 01 (reset): pins to oscillator, cut-off, pull-up off.
// (RULE_06) Main 10 is forbidden; 11 only in group C: clock in plus GPIO.
// (RULE_07) Sub oscillator field 00 releases both sub pins to GPIO.
// (RULE_08) Sub 01 (reset): pins to oscillator, pull-up off; 10 forbidden.
// (RULE_09) Sub field 11 only in group C: first pin clock in, second GPIO.
// (RULE_10) Main field 01 alone never starts the main oscillator.
// (RULE_11) Sub field 01 alone never starts the sub oscillator.
// (RULE_12) External clock in group B: fields 01, GPIO direction input. The code sets clk_in at main 01 in group A only.
// (RULE_13) Deep-standby reset keeps the selection; only system reset clears.
// (RULE_14) USB ch1 field at bit 5 works like USB ch0.
// (RULE_15) Variant group is a parameter; forbidden codes leave pins as GPIO.
module spf_pin_select
  import spf_pkg::*;
#(
  parameter int unsigned GROUP = SPF_GRP_A
) (
  input  wire logic   sys_clk,         // System clock, 20 MHz
  input  wire logic   rst_n,           // System reset, active low
  input  wire logic   dstby_rst_n,     // Deep-standby reset, active low
  input  wire logic   ce,              // Clock enable, freezes all state
  input  spf_req_t    bus_req,         // Register request
  output logic [31:0] rd_data,         // Read data, cycle after read
  input  wire logic   main_osc_enable, // Main oscillator enable
  input  wire logic   sub_osc_enable,  // Sub oscillator enable
  output spf_pair_t   usb0_pads,       // USB ch0 pad controls
  output spf_pair_t   usb1_pads,       // USB ch1 pad controls
  output spf_pair_t   main_pads,       // Main oscillator pad controls
  output spf_pair_t   sub_pads,        // Sub oscillator pad controls
  output logic        main_osc_run,    // Main oscillator running
  output logic        sub_osc_run,     // Sub oscillator running
  output logic        bad_write        // A forbidden code was written
);

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic     wr_sel;
  logic     wr_stat;
  logic     rd_sel;
  logic     rd_stat;
  spf_sel_t sel_q;
  spf_sel_t sel_d;
  spf_sel_t wsel;
  logic [1:0] err_q;
  logic [1:0] err_d;
  logic [1:0] err_set;
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  spf_pair_t  usb0_dec;
  spf_pair_t  usb1_dec;
  spf_pair_t  main_dec;
  spf_pair_t  sub_dec;
  spf_pair_t  usb0_q;
  spf_pair_t  usb1_q;
  spf_pair_t  main_q;
  spf_pair_t  sub_q;
  logic       main_run_q;
  logic       sub_run_q;

  assign wr_sel  = ce && bus_req.wr && (bus_req.addr == SPF_SEL_OFS);
  assign wr_stat = ce && bus_req.wr && (bus_req.addr == SPF_STAT_OFS);
  assign rd_sel  = ce && bus_req.rd && (bus_req.addr == SPF_SEL_OFS);
  assign rd_stat = ce && bus_req.rd && (bus_req.addr == SPF_STAT_OFS);

  // Reserved write bits are dropped; prohibited codes are still stored.
  always_comb begin
    wsel      = '0;
    wsel.usb1 = bus_req.wdata[SPF_USB1_POS];
    wsel.usb0 = bus_req.wdata[SPF_USB0_POS];
    wsel.main = bus_req.wdata[SPF_MAIN_POS +: 2];
    wsel.sub  = bus_req.wdata[SPF_SUB_POS +: 2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection register

  // Deep-standby reset is not an input here on purpose: the pads must
  // keep their function while the core sleeps. // see RULE_13
  always_comb begin
    sel_d = sel_q;
    if (!rst_n) begin
      sel_d.usb1 = SPF_USB_RST;
      sel_d.usb0 = SPF_USB_RST;
      sel_d.main = SPF_MAIN_RST;
      sel_d.sub  = SPF_SUB_RST;
    end else if (wr_sel) begin
      sel_d = wsel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || ce) begin
      sel_q <= sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad control decode

  // The pads are decoded from the next selection so that they change in
  // the same edge as the register and never lag a cycle behind it.
  spf_pair_decode #(
    .KIND  (SPF_KIND_USB),
    .GROUP (GROUP)
  ) u_usb0 (
    .code ({1'b0, sel_d.usb0}),
    .pads (usb0_dec)
  );

  spf_pair_decode #(
    .KIND  (SPF_KIND_USB),
    .GROUP (GROUP)
  ) u_usb1 (
    .code ({1'b0, sel_d.usb1}),
    .pads (usb1_dec)
  );

  spf_pair_decode #(
    .KIND  (SPF_KIND_MAIN),
    .GROUP (GROUP)
  ) u_main (
    .code (sel_d.main),
    .pads (main_dec)
  );

  spf_pair_decode #(
    .KIND  (SPF_KIND_SUB),
    .GROUP (GROUP)
  ) u_sub (
    .code (sel_d.sub),
    .pads (sub_dec)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n || ce) begin
      usb0_q <= usb0_dec; // see RULE_01
      usb1_q <= usb1_dec; // see RULE_14
      main_q <= main_dec; // see RULE_05
      sub_q  <= sub_dec;  // see RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator run

  // Only the enable starts a crystal; the field merely lends the pins.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      main_run_q <= 1'b0;
      sub_run_q  <= 1'b0;
    end else if (ce) begin
      main_run_q <= main_osc_enable &&
                    (sel_q.main == SPF_OSC_XTAL); // see RULE_10
      sub_run_q  <= sub_osc_enable &&
                    (sel_q.sub == SPF_OSC_XTAL);  // see RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forbidden code status

  always_comb begin
    err_set = '0;
    if (wr_sel) begin
      err_set[SPF_ERRM_POS] = !spf_osc_legal(wsel.main, GROUP); // see RULE_06
      err_set[SPF_ERRS_POS] = !spf_osc_legal(wsel.sub, GROUP);  // see RULE_09
    end
    err_d = err_q;
    if (wr_stat) begin
      err_d = err_q & ~bus_req.wdata[1:0];
    end
    // A new fault in the clearing cycle is kept.
    err_d = err_d | err_set;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !dstby_rst_n) begin
      err_q <= '0;
    end else if (ce) begin
      err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Reads have no side effect; unmapped addresses return zero.
  always_comb begin
    rd_data_d = '0;
    if (rd_sel) begin
      rd_data_d = {26'h0, sel_q}; // see RULE_03
    end else if (rd_stat) begin
      rd_data_d = {30'h0, err_q};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !dstby_rst_n) begin
      rd_data_q <= '0;
    end else if (ce) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data      = rd_data_q;
  assign usb0_pads    = usb0_q;
  assign usb1_pads    = usb1_q;
  assign main_pads    = main_q;
  assign sub_pads     = sub_q;
  assign main_osc_run = main_run_q;
  assign sub_osc_run  = sub_run_q;
  assign bad_write    = |err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_usb0_gpio_mode: assert property ( // see RULE_01
    @(posedge sys_clk) disable iff (!rst_n)
    !sel_q.usb0 |-> !usb0_q.p0_func && !usb0_q.p1_func && !usb0_q.p0_cut)
    else $error("USB ch0 pins not GPIO while field is 0");

  a_usb0_usb_mode: assert property ( // see RULE_02
    @(posedge sys_clk) disable iff (!rst_n)
    wr_sel && bus_req.wdata[SPF_USB0_POS] |=>
      usb0_q.p0_func && usb0_q.p1_func && usb0_q.p0_cut && usb0_q.p1_cut)
    else $error("USB ch0 pins not given to USB after write of 1");

  a_read_back_sel: assert property ( // see RULE_03
    @(posedge sys_clk) disable iff (!rst_n || !dstby_rst_n)
    rd_sel && !bus_req.wr |=>
      rd_data == {26'h0, $past(sel_q)} && $stable(sel_q))
    else $error("Read returned wrong value or changed selection");

  a_main_gpio_mode: assert property ( // see RULE_04
    @(posedge sys_clk) disable iff (!rst_n)
    sel_q.main == SPF_OSC_GPIO |->
      !main_q.p0_func && !main_q.p1_func && !main_q.pu_off)
    else $error("Main oscillator pins not released at code 00");

  a_main_xtal_mode: assert property ( // see RULE_05
    @(posedge sys_clk) disable iff (!rst_n)
    sel_q.main == SPF_OSC_XTAL |->
      main_q.p0_func && main_q.p1_func && main_q.p0_cut &&
      main_q.p1_cut && main_q.pu_off)
    else $error("Main oscillator pins not assigned at code 01");

  a_main_ext_clk: assert property ( // see RULE_06
    @(posedge sys_clk) disable iff (!rst_n)
    sel_q.main == SPF_OSC_EXT |->
      (GROUP == SPF_GRP_C) ? (main_q.clk_in && !main_q.p1_func)
                           : (main_q == '0))
    else $error("Main code 11 decoded wrongly for this group");

  a_sub_gpio_mode: assert property ( // see RULE_07
    @(posedge sys_clk) disable iff (!rst_n)
    sel_q.sub == SPF_OSC_GPIO |->
      !sub_q.p0_func && !sub_q.p1_func && !sub_q.p0_cut)
    else $error("Sub oscillator pins not released at code 00");

  a_sub_xtal_mode: assert property ( // see RULE_08
    @(posedge sys_clk) disable iff (!rst_n)
    wr_sel && wsel.sub == SPF_OSC_XTAL |=>
      sub_q.p0_func && sub_q.p1_func && sub_q.pu_off && sub_q.p1_cut)
    else $error("Sub oscillator pins not assigned after write of 01");

  a_sub_ext_clk: assert property ( // see RULE_09
    @(posedge sys_clk) disable iff (!rst_n)
    sel_q.sub == SPF_OSC_EXT |->
      (GROUP == SPF_GRP_C) ? (sub_q.clk_in && !sub_q.p0_cut)
                           : (sub_q == '0))
    else $error("Sub code 11 decoded wrongly for this group");

  a_main_no_start: assert property ( // see RULE_10
    @(posedge sys_clk) disable iff (!rst_n)
    ce && !main_osc_enable |=> !main_osc_run)
    else $error("Main oscillator runs without its enable");

  a_sub_no_start: assert property ( // see RULE_11
    @(posedge sys_clk) disable iff (!rst_n)
    ce && !sub_osc_enable |=> !sub_osc_run)
    else $error("Sub oscillator runs without its enable");

  a_sub_osc_start: assert property ( // see RULE_11
    @(posedge sys_clk) disable iff (!rst_n)
    ce && sub_osc_enable && sel_q.sub == SPF_OSC_XTAL |=> sub_osc_run)
    else $error("Sub oscillator not started by enable at code 01");

  a_dstby_keeps_sel: assert property ( // see RULE_13
    @(posedge sys_clk) disable iff (!rst_n)
    !dstby_rst_n && !wr_sel |=> $stable(sel_q))
    else $error("Deep-standby reset disturbed the selection");

  a_usb1_usb_mode: assert property ( // see RULE_14
    @(posedge sys_clk) disable iff (!rst_n)
    sel_q.usb1 |-> usb1_q.p0_func && usb1_q.p1_func && usb1_q.p1_cut)
    else $error("USB ch1 pins not given to USB at field 1");

  a_bad_code_gpio: assert property ( // see RULE_15
    @(posedge sys_clk) disable iff (!rst_n)
    wr_sel && wsel.main == SPF_OSC_BAD |=>
      main_q == '0 ##1 (!ce || bad_write))
    else $error("Forbidden main code did not leave pins as GPIO");

  a_main_osc_start: assert property ( // see RULE_10
    @(posedge sys_clk) disable iff (!rst_n)
    ce && main_osc_enable && sel_q.main == SPF_OSC_XTAL |=> main_osc_run)
    else $error("Main oscillator not started by enable at code 01");

  a_main_run_gate: assert property ( // see RULE_04
    @(posedge sys_clk) disable iff (!rst_n)
    ce && sel_q.main != SPF_OSC_XTAL |=> !main_osc_run)
    else $error("Main oscillator runs while its pins are not lent");

  a_sub_run_gate: assert property ( // see RULE_07
    @(posedge sys_clk) disable iff (!rst_n)
    ce && sel_q.sub != SPF_OSC_XTAL |=> !sub_osc_run)
    else $error("Sub oscillator runs while its pins are not lent");

  a_sub_bad_status: assert property ( // see RULE_09
    @(posedge sys_clk) disable iff (!rst_n || !dstby_rst_n)
    wr_sel && !spf_osc_legal(wsel.sub, GROUP) |=> bad_write)
    else $error("Forbidden sub code did not raise the status");

  a_usb1_gpio_mode: assert property ( // see RULE_14
    @(posedge sys_clk) disable iff (!rst_n)
    !sel_q.usb1 |-> usb1_q == '0)
    else $error("USB ch1 pins not GPIO while field is 0");

  a_sel_reset_value: assert property ( // see RULE_13
    @(posedge sys_clk)
    !rst_n |=> sel_q == {SPF_USB_RST, SPF_USB_RST, SPF_MAIN_RST, SPF_SUB_RST})
    else $error("System reset did not restore the selection defaults");

  a_rd_idle_zero: assert property ( // see RULE_03
    @(posedge sys_clk) disable iff (!rst_n)
    ce && !bus_req.rd |=> rd_data == '0)
    else $error("Read data did not return to zero after its cycle");

endmodule // spf_pin_select

/* pkg/spf_pkg.sv */
// Package: constants, types and helpers of the special pin function block.
package spf_pkg;

  localparam int unsigned SPF_AW        = 8;
  localparam logic [7:0]  SPF_SEL_OFS   = 8'h00;
  localparam logic [7:0]  SPF_STAT_OFS  = 8'h04;

  localparam int unsigned SPF_SUB_POS   = 0;
  localparam int unsigned SPF_MAIN_POS  = 2;
  localparam int unsigned SPF_USB0_POS  = 4;
  localparam int unsigned SPF_USB1_POS  = 5;
  localparam int unsigned SPF_ERRM_POS  = 0;
  localparam int unsigned SPF_ERRS_POS  = 1;

  localparam logic [1:0]  SPF_OSC_GPIO  = 2'h0;
  localparam logic [1:0]  SPF_OSC_XTAL  = 2'h1;
  localparam logic [1:0]  SPF_OSC_BAD   = 2'h2;
  localparam logic [1:0]  SPF_OSC_EXT   = 2'h3;

  localparam logic        SPF_USB_RST   = 1'h0;
  localparam logic [1:0]  SPF_MAIN_RST  = 2'h1;
  localparam logic [1:0]  SPF_SUB_RST   = 2'h1;

  localparam int unsigned SPF_GRP_A     = 1;
  localparam int unsigned SPF_GRP_B     = 2;
  localparam int unsigned SPF_GRP_C     = 3;

  typedef enum logic [1:0] {
    SPF_KIND_USB,
    SPF_KIND_MAIN,
    SPF_KIND_SUB
  } spf_kind_t;

  // Field order matches the bit layout of the selection register.
  typedef struct packed {
    logic       usb1;
    logic       usb0;
    logic [1:0] main;
    logic [1:0] sub;
  } spf_sel_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } spf_req_t;

  // Pad control of one pin pair; func means taken away from GPIO.
  typedef struct packed {
    logic p0_func;
    logic p1_func;
    logic p0_cut;
    logic p1_cut;
    logic pu_off;
    logic clk_in;
  } spf_pair_t;

  function automatic logic spf_osc_legal(input logic [1:0]  code,
                                         input int unsigned grp);
    return (code == SPF_OSC_GPIO) || (code == SPF_OSC_XTAL) ||
           ((code == SPF_OSC_EXT) && (grp == SPF_GRP_C));
  endfunction

endpackage

/* tb/spf_osc_model.sv */
// Model of the clock control register and oscillator pads beside the block.
module spf_osc_model
  import spf_pkg::*;
(
  input  wire logic sys_clk,         // System clock
  input  wire logic rst_n,           // System reset, active low
  input  wire logic main_req,        // Software asks for main oscillation
  input  wire logic sub_req,         // Software asks for sub oscillation
  input  spf_pair_t main_pads,       // Main pair pad controls
  output logic      main_osc_enable, // Main oscillator enable
  output logic      sub_osc_enable,  // Sub oscillator enable
  output logic      ext_clk_path     // Clock may enter on the main input pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // The enables live in a separate register, so software sets them only
  // after the field write; the field alone must never start anything.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      main_osc_enable <= 1'h0;
      sub_osc_enable  <= 1'h0;
    end else begin
      main_osc_enable <= main_req;
      sub_osc_enable  <= sub_req;
    end
  end

  // An external clock needs the clock input open and the second pin left as GPIO.
  assign ext_clk_path = main_pads.clk_in && !main_pads.p1_func;

endmodule // spf_osc_model

/* tb/spf_pin_select_bench.sv */
// Testbench of the special pin function selection block.
module spf_pin_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spf_pkg::*;

  logic        sys_clk     = 1'h0;
  logic        rst_n       = 1'h0;
  logic        dstby_rst_n = 1'h1;
  logic        ce          = 1'h1;
  logic        main_req    = 1'h0;
  logic        sub_req     = 1'h0;
  spf_req_t    bus_req     = '0;
  logic [31:0] rd_data;
  logic [31:0] rdv;
  logic [31:0] w;
  spf_pair_t   usb0_pads, usb1_pads, main_pads, sub_pads;
  logic        main_osc_enable, sub_osc_enable, ext_clk_path;
  logic        main_osc_run, sub_osc_run, bad_write;
  spf_pair_t   main_pads_a, sub_pads_a;
  logic        bad_write_a;
  int          num_errors = 0;
  int          checks     = 0;
  // Expected pad controls per code 00, 01, 10, 11 in group C.
  logic [5:0]  main_tab [4] = '{6'h01, 6'h3E, 6'h00, 6'h21};
  logic [5:0]  sub_tab  [4] = '{6'h00, 6'h3E, 6'h00, 6'h21};
  // Group A refuses code 11 and lets a clock enter the main input at 01.
  logic [5:0]  main_tab_a [4] = '{6'h00, 6'h3F, 6'h00, 6'h00};
  logic [5:0]  sub_tab_a  [4] = '{6'h01, 6'h3E, 6'h00, 6'h00};

  always #25 sys_clk = ~sys_clk;

  spf_pin_select #(.GROUP(SPF_GRP_C)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .dstby_rst_n(dstby_rst_n), .ce(ce),
    .bus_req(bus_req), .rd_data(rd_data),
    .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
    .usb0_pads(usb0_pads), .usb1_pads(usb1_pads), .main_pads(main_pads),
    .sub_pads(sub_pads), .main_osc_run(main_osc_run),
    .sub_osc_run(sub_osc_run), .bad_write(bad_write));

  spf_osc_model far_side (
    .sys_clk(sys_clk), .rst_n(rst_n), .main_req(main_req),
    .sub_req(sub_req), .main_pads(main_pads),
    .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
    .ext_clk_path(ext_clk_path));

  // A second instance in group A sees the same bus, so that the group
  // dependent decoding is exercised on both sides of the code 11 split.
  spf_pin_select #(.GROUP(SPF_GRP_A)) dut_grp_a (
    .sys_clk(sys_clk), .rst_n(rst_n), .dstby_rst_n(dstby_rst_n), .ce(ce),
    .bus_req(bus_req), .rd_data(),
    .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
    .usb0_pads(), .usb1_pads(), .main_pads(main_pads_a),
    .sub_pads(sub_pads_a), .main_osc_run(), .sub_osc_run(),
    .bad_write(bad_write_a));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Each access leaves the bus idle for one cycle afterwards.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask

  task automatic pulse_reset(input bit standby);
    @(posedge sys_clk);
    if (standby) dstby_rst_n <= 1'h0;
    else rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    dstby_rst_n <= 1'h1;
    rst_n       <= 1'h1;
  endtask

  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    #1;
    check("usb0_pads", 32'(usb0_pads), 32'h0);
    check("usb1_pads", 32'(usb1_pads), 32'h0);
    check("main_pads", 32'(main_pads), 32'h3E);
    check("sub_pads", 32'(sub_pads), 32'h3E);
    check("main_pads_a", 32'(main_pads_a), 32'h3F);
    bus_rd(SPF_SEL_OFS, rdv);
    check("sel_reset", rdv, 32'h05);
    check("main_run", 32'(main_osc_run), 32'h0);
    check("sub_run", 32'(sub_osc_run), 32'h0);
    main_req <= 1'h1;
    sub_req  <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    check("main_run_en", 32'(main_osc_run), 32'h1);
    check("sub_run_en", 32'(sub_osc_run), 32'h1);

    bus_wr(SPF_SEL_OFS, 32'h15);
    check("usb0_take", 32'(usb0_pads[5:2]), 32'hF);
    check("usb1_idle", 32'(usb1_pads), 32'h0);
    bus_wr(SPF_SEL_OFS, 32'h25);
    check("usb1_take", 32'(usb1_pads[5:2]), 32'hF);
    check("usb0_back", 32'(usb0_pads), 32'h0);

    // Every code of each oscillator field, the other field held at 01.
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 4; c++) begin
        w = (f == 0) ? ((32'(c) << 2) | 32'h1) : (32'h4 | 32'(c));
        bus_wr(SPF_SEL_OFS, w);
        if (f == 0) begin
          check("main_pads", 32'(main_pads), 32'(main_tab[c]));
        end else begin
          check("sub_pads", 32'(sub_pads), 32'(sub_tab[c]));
        end
        bus_rd(SPF_SEL_OFS, rdv);
        check("sel_back", rdv, w);
        check("pads_keep", 32'(f ? sub_pads : main_pads),
              32'(f ? sub_tab[c] : main_tab[c]));
        check("pads_grp_a", 32'(f ? sub_pads_a : main_pads_a),
              32'(f ? sub_tab_a[c] : main_tab_a[c]));
        check("ext_clk", 32'(ext_clk_path),
              32'(f == 0 && (c == 0 || c == 3)));
        bus_rd(SPF_STAT_OFS, rdv);
        check("status", rdv, (c == 2) ? 32'(f + 1) : 32'h0);
        check("bad_write", 32'(bad_write), 32'(c == 2));
        check("bad_grp_a", 32'(bad_write_a), 32'(c >= 2));
        check("main_run", 32'(main_osc_run),
              32'(f == 1 || c == 1));
        check("sub_run", 32'(sub_osc_run),
              32'(f == 0 || c == 1));
        bus_wr(SPF_STAT_OFS, 32'h3);
      end
    end

    bus_wr(SPF_SEL_OFS, 32'hFFFF_FFC5);
    bus_rd(SPF_SEL_OFS, rdv);
    check("reserved", rdv, 32'h05);
    bus_wr(8'h08, 32'h3F);
    bus_rd(8'h08, rdv);
    check("unmapped", rdv, 32'h0);
    @(posedge sys_clk);
    ce <= 1'h0;
    bus_wr(SPF_SEL_OFS, 32'h10);
    ce <= 1'h1;
    bus_rd(SPF_SEL_OFS, rdv);
    check("sel_frozen", rdv, 32'h05);

    // Deep standby keeps the selection; system reset restores defaults.
    bus_wr(SPF_SEL_OFS, 32'h31);
    pulse_reset(1'b1);
    bus_rd(SPF_SEL_OFS, rdv);
    check("sel_dstby", rdv, 32'h31);
    check("usb0_dstby", 32'(usb0_pads[5:2]), 32'hF);
    pulse_reset(1'b0);
    bus_rd(SPF_SEL_OFS, rdv);
    check("sel_sysrst", rdv, 32'h05);
    end_of_test();
  end

endmodule // spf_pin_select_bench
